//--- dv/dsp_multiplier_adder_modes_tb.sv
// ********
// Bench for the multiply-add tile
// ********
module dsp_multiplier_adder_modes_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk = 1'b0;
  logic         reset = 1'b1;
  int           fails = 0;
  int           n_tests = 0;
  logic  [17:0] x [8];
  logic  [17:0] ol [8];
  logic [143:0] res;
  logic   [1:0] ovf;
  logic  [17:0] so_d;
  logic  [17:0] so_c;

  always #2 clk = ~clk;
  assign res = {ol[7], ol[6], ol[5], ol[4], ol[3], ol[2], ol[1], ol[0]};

  logic_rows p ();

  dsp_tile dut (
    .clk(clk), .reset(reset), .tile_mode(p.mode), .tile_size(p.size),
    .sign_a(p.sa), .sign_b(p.sb), .add_sub_select_upper(p.up),
    .add_sub_select_lower(p.lo), .accum_load(p.ld), .chain_en(p.ce),
    .coef_load(p.cl), .coef_shift(p.cs), .shift_in_data(p.sd), .shift_in_coef(p.sc),
    .shift_out_data(so_d), .shift_out_coef(so_c),
    .operand_lane_first(p.lane[0]), .operand_lane_second(p.lane[1]),
    .operand_lane_third(p.lane[2]), .operand_lane_fourth(p.lane[3]),
    .operand_lane_fifth(p.lane[4]), .operand_lane_sixth(p.lane[5]),
    .operand_lane_seventh(p.lane[6]), .operand_lane_eighth(p.lane[7]),
    .output_lane_first(ol[0]), .output_lane_second(ol[1]), .output_lane_third(ol[2]),
    .output_lane_fourth(ol[3]), .output_lane_fifth(ol[4]), .output_lane_sixth(ol[5]),
    .output_lane_seventh(ol[6]), .output_lane_eighth(ol[7]), .acc_overflow(ovf)
  );

  // ********
  // Shared helpers
  // ********
  task automatic chk(input logic [143:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send(input dsp_tile_pkg::mode_t m, input dsp_tile_pkg::size_t s,
                      input logic a, b, u, l, input logic [1:0] d);
    @(posedge clk);
    p.cfg(m, s, a, b, u, l, d);
    for (int i = 0; i < 8; i++) p.put(i, x[i]);
  endtask

  // Sign is applied by the operand flag, so mixed signedness is modelled too
  function automatic logic signed [73:0] mul(input logic [35:0] a, b, input int w,
                                             input logic sa, sb);
    logic signed [73:0] u;
    logic signed [73:0] v;
    u = 74'(a & ((36'h1 << w) - 36'h1));
    v = 74'(b & ((36'h1 << w) - 36'h1));
    if (sa && a[w-1]) u = u - (74'sh1 <<< w);
    if (sb && b[w-1]) v = v - (74'sh1 <<< w);
    return u * v;
  endfunction

  function automatic logic signed [73:0] hp(input int k, h, w);
    return mul(36'(x[2*k] >> (9*h)), 36'(x[2*k+1] >> (9*h)), w, 1'b1, 1'b1);
  endfunction

  function automatic logic [143:0] fld(input logic signed [73:0] v, input int n, off);
    return (144'(v) & ((144'h1 << n) - 144'h1)) << off;
  endfunction

  // ********
  // Scenarios
  // ********
  task automatic t_simple;
    logic [143:0] e;
    x = '{18'h2_0001, 18'h0_0003, 18'h3_FFFF, 18'h3_FFFF, 18'h1_2345, 18'h2_0000,
          18'h0_00FF, 18'h1_0001};
    send(dsp_tile_pkg::MODE_SIMPLE, dsp_tile_pkg::SIZE_18, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
    settle(2);
    e = '0;
    for (int k = 0; k < 4; k++) e |= fld(mul(36'(x[2*k]), 36'(x[2*k+1]), 18, 1'b1, 1'b0),
                                        36, 36 * k);
    chk(res, e);
    send(dsp_tile_pkg::MODE_SIMPLE, dsp_tile_pkg::SIZE_9, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
    settle(2);
    e = '0;
    // Half k%2 of unit k/2 lands in output lane k
    for (int k = 0; k < 8; k++) begin
      e |= fld(mul(36'(x[k - k % 2] >> (9 * (k % 2))), 36'(x[k - k % 2 + 1] >> (9 * (k % 2))),
                   9, 1'b1, 1'b0), 18, 18 * k);
    end
    chk(res, e);
  endtask

  task automatic t_wide;
    x = '{18'h3_1234, 18'h0_5678, 18'h2_9ABC, 18'h1_DEF0, 18'h3_FFFF, 18'h3_FFFF,
          18'h3_FFFF, 18'h3_FFFF};
    // Adder mode requested, wide size must still give only the plain product
    send(dsp_tile_pkg::MODE_TWO_ADD, dsp_tile_pkg::SIZE_36, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0);
    settle(2);
    chk(res, fld(mul({x[2], x[0]}, {x[3], x[1]}, 36, 1'h1, 1'h1), 72, 0));
  endtask

  task automatic t_add(input dsp_tile_pkg::mode_t m, input dsp_tile_pkg::size_t s,
                       input logic u, l);
    logic signed [73:0] pr [2][2];
    logic signed [73:0] t;
    logic       [143:0] e;
    int                 w;
    w = (s == dsp_tile_pkg::SIZE_9) ? 9 : 18;
    e = '0;
    for (int k = 0; k < 2; k++) begin
      for (int h = 0; h < 2; h++) begin
        t = hp(2 * k + 1, h, w);
        pr[k][h] = hp(2 * k, h, w) + (((k == 0) ? u : l) ? t : -t);
        if (m == dsp_tile_pkg::MODE_TWO_ADD && (w == 9 || h == 0))
          e |= fld(pr[k][h], 2 * w + 1, 72 * k + 36 * h);
      end
      if (m == dsp_tile_pkg::MODE_FOUR_ADD && w == 9) e |= fld(pr[k][0] + pr[k][1], 20, 72 * k);
    end
    if (m == dsp_tile_pkg::MODE_FOUR_ADD && w == 18) e = fld(pr[0][0] + pr[1][0], 38, 0);
    send(m, s, 1'h1, 1'h1, u, l, 2'h0);
    settle(2);
    chk(res, e);
  endtask

  // Unit lanes are arranged for (a+jb)(c+jd): units ac, bd, ad, bc
  task automatic t_cplx(input dsp_tile_pkg::size_t s, input logic [17:0] a, b, c, d);
    x = '{a, c, b, d, a, d, b, c};
    t_add(dsp_tile_pkg::MODE_TWO_ADD, s, 1'h0, 1'h1);
  endtask

  task automatic t_mac;
    logic [143:0] r1;
    logic  [73:0] p1;
    logic  [73:0] p3;
    x = '{18'h3_FFFF, 18'h3_FFFF, 18'h0_0123, 18'h0_0045, 18'h3_FFFF, 18'h3_FFFF,
          18'h0_0011, 18'h0_0007};
    p1 = mul(36'(x[2]), 36'(x[3]), 18, 1'h0, 1'h0);
    p3 = mul(36'(x[6]), 36'(x[7]), 18, 1'h0, 1'h0);
    send(dsp_tile_pkg::MODE_MAC, dsp_tile_pkg::SIZE_18, 1'h0, 1'h0, 1'h1, 1'h0, 2'h3);
    settle(3);
    chk(res, fld(p1, 52, 0) | fld(p3, 52, 72));
    send(dsp_tile_pkg::MODE_MAC, dsp_tile_pkg::SIZE_18, 1'h0, 1'h0, 1'h1, 1'h0, 2'h0);
    settle(3);
    // Lower accumulator drops below zero on its second step
    chk(144'(ovf), 144'(2'h2));
    settle(1);
    r1 = res;
    settle(1);
    // One step adds on the upper accumulator and subtracts on the lower one
    chk(144'(res[51:0] - r1[51:0]), 144'(p1[51:0]));
    chk(144'(r1[123:72] - res[123:72]), 144'(p3[51:0]));
    chk(144'(ovf), '0);
  endtask

  task automatic t_chain;
    @(posedge clk);
    p.chain(1'h1, 1'h0, 1'h1, 18'h1_2345, 18'h2_0ABC);
    @(posedge clk);
    p.chain(1'h1, 1'h0, 1'h1, 18'h0_0000, 18'h0_0000);
    settle(3);
    chk(144'({so_d, so_c}), 144'({18'h1_2345, 18'h2_0ABC}));
    settle(1);
    chk(144'({so_d, so_c}), '0);
    @(posedge clk);
    p.put(7, 18'h3_C0DE);
    p.chain(1'h1, 1'h1, 1'h0, 18'h0_0000, 18'h0_0000);
    settle(1);
    chk(144'(so_c), 144'(18'h3_C0DE));
    @(posedge clk);
    p.chain(1'h0, 1'h0, 1'h0, 18'h0_0000, 18'h0_0000);
  endtask

  task automatic t_reset;
    @(posedge clk);
    reset <= 1'b1;
    settle(2);
    chk(res, '0);
    chk(144'(ovf), '0);
    @(posedge clk);
    reset <= 1'b0;
  endtask

  initial begin
    repeat (15) @(posedge clk);
    #1;
    chk(res, '0);
    chk(144'(ovf), '0);
    @(posedge clk);
    reset <= 1'b0;
    t_simple();
    t_wide();
    t_cplx(dsp_tile_pkg::SIZE_18, 18'h3_FF85, 18'h0_0A0B, 18'h2_1234, 18'h1_FFFF);
    t_cplx(dsp_tile_pkg::SIZE_9, 18'h1_0F85, 18'h3_0A0B, 18'h0_9234, 18'h2_41FF);
    x = '{18'h0_1234, 18'h3_F00F, 18'h2_0001, 18'h1_5555, 18'h0_00FF, 18'h3_FFFF,
          18'h1_8000, 18'h2_ABCD};
    t_add(dsp_tile_pkg::MODE_FOUR_ADD, dsp_tile_pkg::SIZE_18, 1'h1, 1'h0);
    t_add(dsp_tile_pkg::MODE_FOUR_ADD, dsp_tile_pkg::SIZE_9, 1'h0, 1'h1);
    t_add(dsp_tile_pkg::MODE_TWO_ADD, dsp_tile_pkg::SIZE_18, 1'h1, 1'h1);
    t_mac();
    t_chain();
    t_reset();
    t_simple();
    tally_and_finish();
  end
endmodule

//--- dv/logic_rows.sv
// ********
// Logic rows that feed the tile
// ********
module logic_rows;
  timeunit 1ns;
  timeprecision 1ps;

  dsp_tile_pkg::mode_t mode;
  dsp_tile_pkg::size_t size;
  logic                sa;
  logic                sb;
  logic                up;
  logic                lo;
  logic          [1:0] ld;
  logic                ce;
  logic                cl;
  logic                cs;
  logic         [17:0] sd;
  logic         [17:0] sc;
  logic         [17:0] lane [8];

  initial begin
    mode = dsp_tile_pkg::MODE_SIMPLE;
    size = dsp_tile_pkg::SIZE_18;
    {sa, sb, up, lo, ld, ce, cl, cs, sd, sc} = '0;
    lane = '{default: '0};
  end

  // Called just after a rising edge; values hold until the next call
  task automatic cfg(input dsp_tile_pkg::mode_t m, input dsp_tile_pkg::size_t s,
                     input logic a, b, u, l, input logic [1:0] d);
    mode <= m;
    size <= s;
    sa   <= a;
    sb   <= b;
    up   <= u;
    lo   <= l;
    ld   <= d;
  endtask

  task automatic chain(input logic e, c, h, input logic [17:0] d, k);
    ce <= e;
    cl <= c;
    cs <= h;
    sd <= d;
    sc <= k;
  endtask

  // Lane i comes from its own fixed row
  task automatic put(input int i, input logic [17:0] v);
    lane[i] <= v;
  endtask
endmodule

//--- pkg/dsp_tile_pkg.sv
package dsp_tile_pkg;

  typedef enum logic [1:0] {
    MODE_SIMPLE,
    MODE_MAC,
    MODE_TWO_ADD,
    MODE_FOUR_ADD
  } mode_t;

  typedef enum logic [1:0] {
    SIZE_9,
    SIZE_18,
    SIZE_36
  } size_t;

endpackage

//--- pkg/dsp_tile_regs.svh
`ifndef DSP_TILE_REGS_SVH
`define DSP_TILE_REGS_SVH

// ****************************************
// Datapath widths
// ****************************************
`define OP_W    18
`define HALF_W  9
`define PROD_W  36
`define PAIR_W  38
`define ACC_W   52
`define WIDE_W  72
`define OUT_W   144

// ****************************************
// Lane and unit counts
// ****************************************
`define LANES   8
`define UNITS   4
`define ACCS    2

// ****************************************
// Result positions in the output lanes
// ****************************************
`define POS_Q1  36
`define POS_Q2  72
`define POS_Q3  108

`endif

//--- rtl/dsp_pair_adder.sv
`include "dsp_tile_regs.svh"

module dsp_pair_adder (
  // Products
  input  wire logic [`PROD_W-1:0] x,
  input  wire logic [`PROD_W-1:0] y,
  // Controls
  input  wire logic               half,
  input  wire logic               add,
  input  wire logic               sgn,
  // Result
  output logic      [`PAIR_W-1:0] res
);

  logic [`PROD_W:0] full;
  logic [`OP_W:0]   lo;
  logic [`OP_W:0]   hi;
  logic             fill;

  // One bit of growth keeps add and subtract exact
  always_comb begin
    fill = sgn | !add;
    if (add) begin
      full = {sgn & x[`PROD_W-1], x} + {sgn & y[`PROD_W-1], y};
      lo   = {sgn & x[`OP_W-1], x[`OP_W-1:0]} + {sgn & y[`OP_W-1], y[`OP_W-1:0]};
      hi   = {sgn & x[`PROD_W-1], x[`PROD_W-1:`OP_W]}
           + {sgn & y[`PROD_W-1], y[`PROD_W-1:`OP_W]};
    end else begin
      full = {sgn & x[`PROD_W-1], x} - {sgn & y[`PROD_W-1], y};
      lo   = {sgn & x[`OP_W-1], x[`OP_W-1:0]} - {sgn & y[`OP_W-1], y[`OP_W-1:0]};
      hi   = {sgn & x[`PROD_W-1], x[`PROD_W-1:`OP_W]}
           - {sgn & y[`PROD_W-1], y[`PROD_W-1:`OP_W]};
    end
    if (half) begin
      res = {hi, lo};
    end else begin
      res = {fill & full[`PROD_W], full};
    end
  end

endmodule

//--- rtl/dsp_product_unit.sv
`include "dsp_tile_regs.svh"

module dsp_product_unit (
  // Operands
  input  wire logic [`OP_W-1:0]   a,
  input  wire logic [`OP_W-1:0]   b,
  // Controls
  input  wire logic               sign_a,
  input  wire logic               sign_b,
  input  wire logic               half,
  // Result
  output logic      [`PROD_W-1:0] product
);

  // One extra bit per operand lets both signed and unsigned use one multiplier
  logic signed [`OP_W:0]     ax;
  logic signed [`OP_W:0]     bx;
  logic signed [`OP_W*2+1:0] full;
  logic signed [`HALF_W:0]   ah [2];
  logic signed [`HALF_W:0]   bh [2];
  logic signed [`OP_W+1:0]   ph [2];

  always_comb begin
    ax   = {sign_a & a[`OP_W-1], a};
    bx   = {sign_b & b[`OP_W-1], b};
    full = ax * bx;
  end

  for (genvar h = 0; h < 2; h++) begin : g_half
    always_comb begin
      ah[h] = {sign_a & a[`HALF_W*h+`HALF_W-1], a[`HALF_W*h +: `HALF_W]};
      bh[h] = {sign_b & b[`HALF_W*h+`HALF_W-1], b[`HALF_W*h +: `HALF_W]};
      ph[h] = ah[h] * bh[h];
    end
  end

  always_comb begin
    if (half) begin
      product = {ph[1][`OP_W-1:0], ph[0][`OP_W-1:0]};
    end else begin
      product = full[`PROD_W-1:0];
    end
  end

endmodule

//--- rtl/dsp_tile.sv
// How it works
// - Pair adders combine two products each
// - Complex product: real difference, imaginary sum
// - Nine-bit operands give two complex products
// - Summation adds two pair results together
// - One size setting serves all four multipliers
// - Data and coefficient chains feed FIR taps
// - One tile forms a four tap FIR
// - Plain mode: eight, four or one products
// - Two 52-bit accumulators, none at 36 bits
// - Wide product mode bypasses every adder
// - Counts assume operands share one signedness
// - Outputs and shift chains cascade onward
// - Eight lane units, 18 in, 18 out
// - Input routing takes ten neighbour links
// - Nine output bits each side, all routable
// - Exactly one operating mode per tile
`include "dsp_tile_regs.svh"

module dsp_tile (
  // Clock and reset
  input  wire logic                [0:0] clk,
  input  wire logic                      reset,
  // Tile configuration
  input  wire dsp_tile_pkg::mode_t       tile_mode,
  input  wire dsp_tile_pkg::size_t       tile_size,
  // Control bus
  input  wire logic                      sign_a,
  input  wire logic                      sign_b,
  input  wire logic                      add_sub_select_upper,
  input  wire logic                      add_sub_select_lower,
  input  wire logic                [1:0] accum_load,
  // Shift chains
  input  wire logic                      chain_en,
  input  wire logic                      coef_load,
  input  wire logic                      coef_shift,
  input  wire logic      [`OP_W-1:0]     shift_in_data,
  input  wire logic      [`OP_W-1:0]     shift_in_coef,
  output logic           [`OP_W-1:0]     shift_out_data,
  output logic           [`OP_W-1:0]     shift_out_coef,
  // Operand lanes
  input  wire logic      [`OP_W-1:0]     operand_lane_first,
  input  wire logic      [`OP_W-1:0]     operand_lane_second,
  input  wire logic      [`OP_W-1:0]     operand_lane_third,
  input  wire logic      [`OP_W-1:0]     operand_lane_fourth,
  input  wire logic      [`OP_W-1:0]     operand_lane_fifth,
  input  wire logic      [`OP_W-1:0]     operand_lane_sixth,
  input  wire logic      [`OP_W-1:0]     operand_lane_seventh,
  input  wire logic      [`OP_W-1:0]     operand_lane_eighth,
  // Output lanes
  output logic           [`OP_W-1:0]     output_lane_first,
  output logic           [`OP_W-1:0]     output_lane_second,
  output logic           [`OP_W-1:0]     output_lane_third,
  output logic           [`OP_W-1:0]     output_lane_fourth,
  output logic           [`OP_W-1:0]     output_lane_fifth,
  output logic           [`OP_W-1:0]     output_lane_sixth,
  output logic           [`OP_W-1:0]     output_lane_seventh,
  output logic           [`OP_W-1:0]     output_lane_eighth,
  // Status
  output logic           [`ACCS-1:0]     acc_overflow
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [`OP_W-1:0]    lane_in [`LANES];
  logic [`OP_W-1:0]    out_lane [`LANES];
  logic [`OP_W-1:0]    a_q [`UNITS];
  logic [`OP_W-1:0]    b_q [`UNITS];
  dsp_tile_pkg::mode_t mode_q;
  dsp_tile_pkg::size_t size_q;
  logic                sa_q;
  logic                sb_q;
  logic [1:0]          sel_q;
  logic [`ACCS-1:0]    load_q;
  logic                sgn;
  logic                half;
  logic [`PROD_W-1:0]  prod [`UNITS];
  logic [`PAIR_W-1:0]  pair [2];
  logic [`PAIR_W-1:0]  sum18;
  logic [`OP_W+1:0]    sum9 [2];
  logic signed [`WIDE_W+1:0] wide;
  logic [`ACC_W-1:0]   acc [`ACCS];
  logic [`ACC_W-1:0]   acc_prod [`ACCS];
  logic [`ACC_W:0]     acc_sum [`ACCS];
  logic [`ACC_W-1:0]   next_acc [`ACCS];
  logic [`ACCS-1:0]    next_ovf;
  logic                acc_run;
  logic [`OUT_W-1:0]   next_out;
  logic [`OUT_W-1:0]   out_q;

  // Sign-extend a pair half for the summation stage
  function automatic logic [`OP_W+1:0] grow(input logic [`OP_W:0] v, input logic add,
                                            input logic s);
    grow = {(s | !add) & v[`OP_W], v};
  endfunction

  // Bring a product up to accumulator width
  function automatic logic [`ACC_W-1:0] ext_prod(input logic [`PROD_W-1:0] p,
                                                 input logic h, input logic s);
    if (h) begin
      ext_prod = {{(`ACC_W-`OP_W){s & p[`OP_W-1]}}, p[`OP_W-1:0]};
    end else begin
      ext_prod = {{(`ACC_W-`PROD_W){s & p[`PROD_W-1]}}, p};
    end
  endfunction

  // ****************************************
  // Operand lanes and input stage
  // ****************************************
  // Lane k of the tile faces logic row k; routing into the lanes is outside
  always_comb begin
    lane_in[0] = operand_lane_first;
    lane_in[1] = operand_lane_second;
    lane_in[2] = operand_lane_third;
    lane_in[3] = operand_lane_fourth;
    lane_in[4] = operand_lane_fifth;
    lane_in[5] = operand_lane_sixth;
    lane_in[6] = operand_lane_seventh;
    lane_in[7] = operand_lane_eighth;
  end

  // Controls are registered with the operands so they match the datapath
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= dsp_tile_pkg::MODE_SIMPLE;
      size_q <= dsp_tile_pkg::SIZE_18;
      sa_q   <= 1'b0;
      sb_q   <= 1'b0;
      sel_q  <= 2'h0;
      load_q <= 2'h0;
    end else begin
      mode_q <= tile_mode;
      size_q <= tile_size;
      sa_q   <= sign_a;
      sb_q   <= sign_b;
      sel_q  <= {add_sub_select_lower, add_sub_select_upper};
      load_q <= accum_load;
    end
  end

  // Data chain: each stage takes the previous one, so unit k sees x[n-k]
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < `UNITS; k++) begin
        a_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < `UNITS; k++) begin
        if (!chain_en) begin
          a_q[k] <= lane_in[2*k];
        end else if (k == 0) begin
          a_q[k] <= shift_in_data;
        end else begin
          a_q[k] <= a_q[k-1];
        end
      end
    end
  end

  // Coefficient chain: parallel load wins over a serial shift
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < `UNITS; k++) begin
        b_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < `UNITS; k++) begin
        if (!chain_en || coef_load) begin
          b_q[k] <= lane_in[2*k+1];
        end else if (coef_shift) begin
          b_q[k] <= (k == 0) ? shift_in_coef : b_q[k-1];
        end
      end
    end
  end

  assign shift_out_data = a_q[`UNITS-1];
  assign shift_out_coef = b_q[`UNITS-1];

  // ****************************************
  // Multipliers and first-stage adders
  // ****************************************
  assign sgn  = sa_q | sb_q;
  assign half = (size_q == dsp_tile_pkg::SIZE_9);

  for (genvar k = 0; k < `UNITS; k++) begin : g_unit
    dsp_product_unit u_prod (
      .a       (a_q[k]),
      .b       (b_q[k]),
      .sign_a  (sa_q),
      .sign_b  (sb_q),
      .half    (half),
      .product (prod[k])
    );
  end

  // Upper select steers units 0 and 1, lower steers units 2 and 3
  for (genvar k = 0; k < 2; k++) begin : g_pair
    dsp_pair_adder u_pair (
      .x    (prod[2*k]),
      .y    (prod[2*k+1]),
      .half (half),
      .add  (sel_q[k]),
      .sgn  (sgn),
      .res  (pair[k])
    );
  end

  // ****************************************
  // Summation and wide product
  // ****************************************
  always_comb begin
    sum18 = pair[0] + pair[1];
    for (int k = 0; k < 2; k++) begin
      sum9[k] = grow(pair[k][`OP_W:0], sel_q[k], sgn)
              + grow(pair[k][`PAIR_W-1:`OP_W+1], sel_q[k], sgn);
    end
  end

  // Wide mode joins unit 0 and 1 operands into one product
  assign wide = $signed({sa_q & a_q[1][`OP_W-1], a_q[1], a_q[0]})
              * $signed({sb_q & b_q[1][`OP_W-1], b_q[1], b_q[0]});

  // ****************************************
  // Accumulators
  // ****************************************
  // Units 1 and 3 feed the accumulators; units 0 and 2 sit idle here
  assign acc_run = (mode_q == dsp_tile_pkg::MODE_MAC) && (size_q != dsp_tile_pkg::SIZE_36);

  for (genvar k = 0; k < `ACCS; k++) begin : g_acc
    assign acc_prod[k] = ext_prod(prod[2*k+1], half, sgn);
    assign acc_sum[k]  = sel_q[k] ? {sgn & acc[k][`ACC_W-1], acc[k]}
                                    + {sgn & acc_prod[k][`ACC_W-1], acc_prod[k]}
                                  : {sgn & acc[k][`ACC_W-1], acc[k]}
                                    - {sgn & acc_prod[k][`ACC_W-1], acc_prod[k]};
    assign next_acc[k] = load_q[k] ? acc_prod[k] : acc_sum[k][`ACC_W-1:0];
    assign next_ovf[k] = !load_q[k] && (sgn ? acc_sum[k][`ACC_W] ^ acc_sum[k][`ACC_W-1]
                                            : acc_sum[k][`ACC_W]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < `ACCS; k++) begin
        acc[k] <= '0;
      end
      acc_overflow <= 2'h0;
    end else if (acc_run) begin
      for (int k = 0; k < `ACCS; k++) begin
        acc[k] <= next_acc[k];
      end
      acc_overflow <= next_ovf;
    end else begin
      acc_overflow <= 2'h0;
    end
  end

  // ****************************************
  // Output selection and output register
  // ****************************************
  always_comb begin
    next_out = '0;
    if (size_q == dsp_tile_pkg::SIZE_36) begin
      next_out[`WIDE_W-1:0] = wide[`WIDE_W-1:0];
    end else begin
      case (mode_q)
        dsp_tile_pkg::MODE_SIMPLE: begin
          next_out = {prod[3], prod[2], prod[1], prod[0]};
        end
        dsp_tile_pkg::MODE_MAC: begin
          next_out[`ACC_W-1:0]       = next_acc[0];
          next_out[`POS_Q2 +: `ACC_W] = next_acc[1];
        end
        dsp_tile_pkg::MODE_TWO_ADD: begin
          if (half) begin
            next_out[0 +: `OP_W+1]       = pair[0][`OP_W:0];
            next_out[`POS_Q1 +: `OP_W+1] = pair[0][`PAIR_W-1:`OP_W+1];
            next_out[`POS_Q2 +: `OP_W+1] = pair[1][`OP_W:0];
            next_out[`POS_Q3 +: `OP_W+1] = pair[1][`PAIR_W-1:`OP_W+1];
          end else begin
            next_out[`PROD_W:0]           = pair[0][`PROD_W:0];
            next_out[`POS_Q2 +: `PROD_W+1] = pair[1][`PROD_W:0];
          end
        end
        dsp_tile_pkg::MODE_FOUR_ADD: begin
          if (half) begin
            next_out[0 +: `OP_W+2]       = sum9[0];
            next_out[`POS_Q2 +: `OP_W+2] = sum9[1];
          end else begin
            next_out[`PAIR_W-1:0] = sum18;
          end
        end
        default: begin
          next_out = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= '0;
    end else begin
      out_q <= next_out;
    end
  end

  // Low nine bits of a lane face the left row, high nine the right row
  for (genvar k = 0; k < `LANES; k++) begin : g_out
    assign out_lane[k] = out_q[`OP_W*k +: `OP_W];
  end

  assign output_lane_first   = out_lane[0];
  assign output_lane_second  = out_lane[1];
  assign output_lane_third   = out_lane[2];
  assign output_lane_fourth  = out_lane[3];
  assign output_lane_fifth   = out_lane[4];
  assign output_lane_sixth   = out_lane[5];
  assign output_lane_seventh = out_lane[6];
  assign output_lane_eighth  = out_lane[7];

  // ****************************************
  // Checks
  // ****************************************
  logic signed [`PROD_W:0] chk_p [`UNITS];

  always_comb begin
    for (int k = 0; k < `UNITS; k++) begin
      chk_p[k] = 37'($signed({sa_q & a_q[k][`OP_W-1], a_q[k]})
                   * $signed({sb_q & b_q[k][`OP_W-1], b_q[k]}));
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_complex_real_part: assert property (
    (mode_q == dsp_tile_pkg::MODE_TWO_ADD && size_q == dsp_tile_pkg::SIZE_18 && !sel_q[0])
    |=> out_q[`PROD_W:0] == $past(37'(chk_p[0] - chk_p[1])))
    else $error("real part is not the product difference");
  a_complex_imag_part: assert property (
    (mode_q == dsp_tile_pkg::MODE_TWO_ADD && size_q == dsp_tile_pkg::SIZE_18 && sel_q[1])
    |=> out_q[`POS_Q2 +: `PROD_W+1] == $past(37'(chk_p[2] + chk_p[3])))
    else $error("imaginary part is not the product sum");
  a_four_product_sum: assert property (
    (mode_q == dsp_tile_pkg::MODE_FOUR_ADD && size_q == dsp_tile_pkg::SIZE_18 && sgn)
    |=> out_q[`PAIR_W-1:0] == $past(38'(
          (sel_q[0] ? chk_p[0] + chk_p[1] : chk_p[0] - chk_p[1])
        + (sel_q[1] ? chk_p[2] + chk_p[3] : chk_p[2] - chk_p[3]))))
    else $error("four product sum mismatch");
  a_plain_product: assert property (
    (mode_q == dsp_tile_pkg::MODE_SIMPLE && size_q == dsp_tile_pkg::SIZE_18)
    |=> out_q[`PROD_W-1:0] == $past(chk_p[0][`PROD_W-1:0]))
    else $error("plain product mismatch");
  a_wide_no_adder: assert property (
    (size_q == dsp_tile_pkg::SIZE_36)
    |=> out_q[`OUT_W-1:`WIDE_W] == '0 && acc_overflow == 2'h0 && $stable(acc[0]))
    else $error("wide mode used an adder stage");
  a_acc_load_value: assert property (
    (acc_run && load_q[0] && size_q == dsp_tile_pkg::SIZE_18)
    |=> acc[0] == $past(52'(chk_p[1])) && out_q[`ACC_W-1:0] == acc[0])
    else $error("accumulator load mismatch");
  a_acc_add_step: assert property (
    (acc_run && !load_q[1] && size_q == dsp_tile_pkg::SIZE_18)
    |=> acc[1] == ($past(sel_q[1]) ? 52'($past(acc[1]) + $past(52'(chk_p[3])))
                                   : 52'($past(acc[1]) - $past(52'(chk_p[3])))))
    else $error("accumulator add step mismatch");
  a_data_chain_step: assert property (
    chain_en ##1 chain_en ##1 chain_en |=> a_q[2] == $past(shift_in_data, 3)
                                        && shift_out_data == a_q[3])
    else $error("data chain did not advance");
  a_coef_serial_load: assert property (
    (chain_en && coef_shift && !coef_load) |=> b_q[0] == $past(shift_in_coef))
    else $error("coefficient did not shift in");

  c_complex_mult: cover property (mode_q == dsp_tile_pkg::MODE_TWO_ADD && !sel_q[0] && sel_q[1]);
  c_fir_taps: cover property ((mode_q == dsp_tile_pkg::MODE_FOUR_ADD && chain_en) [*4]);
  c_acc_overflow: cover property (acc_overflow != 2'h0);
  c_wide_mode: cover property (size_q == dsp_tile_pkg::SIZE_36);

endmodule
